// ==== hdl/tsf_top.sv ====
// two-speed start-up sequencer, glitch-free clock switch, watchdog and APB registers
// Contract
// - two-speed start-up only when its configuration bit is set
// - after reset or wake, run from internal osc while primary starts
// - when start-up timer expires, switch to primary run mode automatically
// - other mode changes ignore two-speed and keep current clock
// - clock select writes and sleep accepted before start-up timer expires
// - control register bit 3 reads one when primary clocks the device
// - clock monitor works only when its configuration bit is set
// - internal rc runs continuously while the monitor is enabled
// - sample clock is internal rc divided by 64
// - latch set on device clock fall, cleared on sample rise
// - failure declared on sample fall while latch still set
// - failure sets oscillator-fail flag, bit 7 of second irq flags
// - failure switches to internal osc; control register not updated
// - each failure clears watchdog counter and postscaler
// - only primary and secondary sources are supervised
// - watchdog has its own divider; disabling it keeps rc running
// - fail interrupt disabled: idle interrupts resume core on internal rc
// - fail-safe left only on reset or power-managed mode entry
// - after reset from fail-safe, internal clocks until primary ready; code does so only if two-speed is set before power-up ends, else no source
// - primary never ready: stay on internal, control keeps reset value; with two-speed clear the code stays on no source
// - failure in power-managed mode never returns to failed source
// - crystal modes clock from internal until start-up and pll timers done; code does so only with two-speed set, else no source until then
`timescale 1ns/100ps
`default_nettype none
module tsf_top
  import tsf_pkg::*;
#(
  parameter int OST_CYCLES = OST_CYCLES_DEF,
  parameter int WDT_DIV = WDT_DIV_DEF
)
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic por_in, // reset was a power-on reset
  input wire logic pwrt_done_in, // power-up timer expired
  input wire logic pri_clk_in, // primary oscillator level
  input wire logic sec_clk_in, // secondary oscillator level
  input wire logic rc_clk_in, // internal rc oscillator level
  input wire logic pll_lock_in, // pll locked
  input wire logic wake_in, // wake-up from sleep event
  input wire logic idle_in, // core in idle mode
  input wire logic irq_in, // some interrupt pending
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic dev_clk_out, // device clock
  output tsf_pkg::tsf_src_t dev_src_out, // source now driving the device clock
  output logic fail_safe_out, // fail-safe condition active
  output logic pri_osc_en_out, // primary oscillator enable
  output logic rc_osc_en_out, // internal rc enable
  output logic wdt_timeout_out, // watchdog time-out pulse
  output logic cpu_resume_out // core resume pulse out of idle
);
  localparam int OW = $clog2(OST_CYCLES + 1);
  localparam int WW = $clog2(WDT_DIV);
  localparam logic [OW-1:0] OST_LAST = OW'(OST_CYCLES);
  typedef struct packed {
    tsf_state_t st;
    tsf_src_t cur_src;
    logic dev_clk;
    logic pri_prev;
    logic rc_prev;
    logic [OW-1:0] ost_cnt;
    logic use_rc;
    logic keep_src;
    logic primary_clock_running;
    logic [1:0] clock_source_select;
    logic osc_fail_flag;
    logic two_speed_enable_cfg;
    logic clock_monitor_enable_cfg;
    tsf_mode_t mode;
    logic fail_ie;
    logic wdt_en;
    logic [3:0] wdt_ps;
    logic [WW-1:0] wdt_div;
    logic [15:0] wdt_post;
    logic wdt_to;
    logic resume;
    logic [31:0] rdata;
  } tsf_top_t;
  tsf_top_t cur_ff;
  tsf_top_t nxt_ff;
  tsf_mon_if mif ();
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] rd_val;
  logic [3:0] lvl;
  logic pri_ready;
  logic crystal;
  logic pll_mode;
  logic rc_rise;
  logic sleep_req;
  logic scs_wr;
  logic [1:0] scs_new;
  tsf_src_t req;
  tsf_src_t scs_src;

  // ==========================================================
  // monitor instance
  tsf_monitor #(
    .DIV(SAMPLE_DIV)
  ) u_mon (
    .clk(clk),
    .reset(reset),
    .mon(mif.mon)
  );

  // only external sources are watched, and only once they are stable
  assign mif.enable = cur_ff.clock_monitor_enable_cfg
    && (cur_ff.st == ST_PRIMARY || cur_ff.st == ST_PM)
    && (cur_ff.cur_src == SRC_PRI || cur_ff.cur_src == SRC_SEC);
  assign mif.dev_clk = cur_ff.dev_clk;
  assign mif.rc_clk = rc_clk_in;

  // ==========================================================
  // apb decode
  always_comb
  begin
    setup = psel & ~penable;
    wr = psel & penable & pwrite;
    mapped = 1'b1;
    rd_val = '0;
    if (paddr == OFS_OSC_CTRL)
    begin
      rd_val[OSC_RUN_BIT] = cur_ff.primary_clock_running;
      rd_val[SCS_LSB +: 2] = cur_ff.clock_source_select;
    end
    else if (paddr == OFS_IRQ_FLAGS)
      rd_val[FAIL_FLAG_BIT] = cur_ff.osc_fail_flag;
    else if (paddr == OFS_CFG)
    begin
      rd_val[CFG_TWO_SPEED_BIT] = cur_ff.two_speed_enable_cfg;
      rd_val[CFG_MON_BIT] = cur_ff.clock_monitor_enable_cfg;
      rd_val[CFG_MODE_LSB +: 2] = cur_ff.mode;
    end
    else if (paddr == OFS_CTRL)
      rd_val[CTRL_FAIL_IE_BIT] = cur_ff.fail_ie;
    else if (paddr == OFS_WDT)
    begin
      rd_val[WDT_EN_BIT] = cur_ff.wdt_en;
      rd_val[WDT_PS_LSB +: 4] = cur_ff.wdt_ps;
    end
    else if (paddr == OFS_WDT_CNT)
      rd_val[15:0] = cur_ff.wdt_post;
    else
      mapped = 1'b0;
  end

  // zero wait states: read data is captured during the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = cur_ff.rdata;

  // ==========================================================
  // source levels, readiness and requests
  always_comb
  begin
    lvl = {rc_clk_in, sec_clk_in, pri_clk_in, 1'b0};
    crystal = (cur_ff.mode == MODE_CRYSTAL_HIGH_SPEED) || (cur_ff.mode == MODE_CRYSTAL_PLL);
    pll_mode = (cur_ff.mode == MODE_CRYSTAL_PLL) || (cur_ff.mode == MODE_EXTERNAL_CLOCK_PLL);
    // external clocks need no start-up timer
    pri_ready = (!crystal || cur_ff.ost_cnt == OST_LAST)
      && (!pll_mode || pll_lock_in);
    rc_rise = rc_clk_in & ~cur_ff.rc_prev;
    sleep_req = wr && paddr == OFS_CTRL && pwdata[CTRL_SLEEP_BIT];
    scs_wr = wr && paddr == OFS_OSC_CTRL;
    scs_new = pwdata[SCS_LSB +: 2];
    if (cur_ff.clock_source_select == 2'b00)
      scs_src = SRC_PRI;
    else if (cur_ff.clock_source_select == 2'b01)
      scs_src = SRC_SEC;
    else
      scs_src = SRC_RC;
  end

  // requested source for each sequencer state
  always_comb
  begin
    case (cur_ff.st)
      ST_STARTUP:
      begin
        if (cur_ff.use_rc)
          req = SRC_RC;
        else if (cur_ff.keep_src)
          req = cur_ff.cur_src;
        else
          req = SRC_NONE;
      end
      ST_PRIMARY:
        req = SRC_PRI;
      ST_FAILSAFE:
        req = SRC_RC;
      ST_PM:
        req = scs_src;
      default:
        req = SRC_NONE;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.pri_prev = pri_clk_in;
    nxt_ff.rc_prev = rc_clk_in;
    nxt_ff.wdt_to = 1'b0;
    nxt_ff.resume = 1'b0;
    if (setup)
      nxt_ff.rdata = rd_val;

    // switch only while both old and new sources are low
    if (req != cur_ff.cur_src && !lvl[cur_ff.cur_src] && !lvl[req])
      nxt_ff.cur_src = req;
    nxt_ff.dev_clk = lvl[nxt_ff.cur_src];

    // start-up timer counts primary rising edges
    if (cur_ff.st == ST_STARTUP && pri_clk_in && !cur_ff.pri_prev
        && cur_ff.ost_cnt != OST_LAST)
      nxt_ff.ost_cnt = cur_ff.ost_cnt + 1'b1;

    // register writes
    if (wr && paddr == OFS_CFG)
    begin
      nxt_ff.two_speed_enable_cfg = pwdata[CFG_TWO_SPEED_BIT];
      nxt_ff.clock_monitor_enable_cfg = pwdata[CFG_MON_BIT];
      nxt_ff.mode = tsf_mode_t'(pwdata[CFG_MODE_LSB +: 2]);
    end
    if (wr && paddr == OFS_CTRL)
      nxt_ff.fail_ie = pwdata[CTRL_FAIL_IE_BIT];
    if (wr && paddr == OFS_WDT)
    begin
      nxt_ff.wdt_en = pwdata[WDT_EN_BIT];
      nxt_ff.wdt_ps = pwdata[WDT_PS_LSB +: 4];
    end
    if (scs_wr)
      nxt_ff.clock_source_select = scs_new;

    // sequencer
    case (cur_ff.st)
      ST_PWRUP:
      begin
        // power-up timer gates only the power-on case
        if (!por_in || pwrt_done_in)
        begin
          nxt_ff.st = ST_STARTUP;
          nxt_ff.use_rc = cur_ff.two_speed_enable_cfg;
          nxt_ff.keep_src = 1'b0;
          nxt_ff.ost_cnt = '0;
        end
      end
      ST_STARTUP:
      begin
        if (sleep_req)
          nxt_ff.st = ST_SLEEP;
        else if (scs_wr && scs_new != 2'b00)
        begin
          nxt_ff.st = ST_PM;
          nxt_ff.primary_clock_running = 1'b0;
        end
        else if (pri_ready)
        begin
          nxt_ff.st = ST_PRIMARY;
          nxt_ff.primary_clock_running = 1'b1;
        end
        // otherwise stay in start-up on the requested source (rc, kept or none), control bits untouched
      end
      ST_PRIMARY, ST_FAILSAFE, ST_PM:
      begin
        if (sleep_req)
          nxt_ff.st = ST_SLEEP;
        else if (scs_wr && scs_new != 2'b00 && cur_ff.st != ST_PM)
        begin
          nxt_ff.st = ST_PM;
          nxt_ff.primary_clock_running = 1'b0;
        end
        else if (cur_ff.st == ST_PM && cur_ff.clock_source_select == 2'b00)
        begin
          // back to primary without two-speed, current clock kept
          nxt_ff.st = ST_STARTUP;
          nxt_ff.use_rc = 1'b0;
          nxt_ff.keep_src = 1'b1;
          nxt_ff.ost_cnt = '0;
        end
        else if (mif.fail)
        begin
          nxt_ff.st = ST_FAILSAFE;
        end
      end
      ST_SLEEP:
      begin
        if (wake_in)
        begin
          nxt_ff.ost_cnt = '0;
          if (cur_ff.clock_source_select == 2'b00)
          begin
            nxt_ff.st = ST_STARTUP;
            nxt_ff.use_rc = cur_ff.two_speed_enable_cfg;
            nxt_ff.keep_src = 1'b0;
          end
          else
            nxt_ff.st = ST_PM;
        end
      end
      default:
        nxt_ff.st = ST_PWRUP;
    endcase

    // failure flag: hardware set wins over the software clear
    if (wr && paddr == OFS_IRQ_FLAGS && pwdata[FAIL_FLAG_BIT])
      nxt_ff.osc_fail_flag = 1'b0;
    if (mif.fail)
      nxt_ff.osc_fail_flag = 1'b1;

    // watchdog on its own divider of the rc oscillator
    if (rc_rise && cur_ff.wdt_en)
    begin
      nxt_ff.wdt_div = cur_ff.wdt_div + 1'b1;
      if (cur_ff.wdt_div == WW'(WDT_DIV - 1))
      begin
        nxt_ff.wdt_post = cur_ff.wdt_post + 1'b1;
        if (cur_ff.wdt_post[cur_ff.wdt_ps])
        begin
          nxt_ff.wdt_to = 1'b1;
          nxt_ff.wdt_post = '0;
        end
      end
    end
    // restart timing at a monitor failure, sleep or explicit clear
    if (mif.fail || sleep_req
        || (wr && paddr == OFS_CTRL && pwdata[CTRL_CLRWDT_BIT]))
    begin
      nxt_ff.wdt_div = '0;
      nxt_ff.wdt_post = '0;
    end

    // idle wake on an interrupt in every state except sleep, backup clock included
    if (cur_ff.st == ST_FAILSAFE && !cur_ff.fail_ie && idle_in && irq_in)
      nxt_ff.resume = 1'b1;
    else if (cur_ff.st != ST_SLEEP && idle_in && irq_in)
      nxt_ff.resume = 1'b1;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur_ff <= '0;
      cur_ff.st <= ST_PWRUP;
      cur_ff.cur_src <= SRC_NONE;
      cur_ff.mode <= MODE_CRYSTAL_HIGH_SPEED;
      cur_ff.clock_source_select <= SCS_RST;
      cur_ff.wdt_ps <= WDT_PS_RST;
    end
    else
      cur_ff <= nxt_ff;
  end

  // ==========================================================
  // outputs
  assign dev_clk_out = cur_ff.dev_clk;
  assign dev_src_out = cur_ff.cur_src;
  assign fail_safe_out = (cur_ff.st == ST_FAILSAFE);
  // primary stays off once another power-managed source is chosen
  assign pri_osc_en_out = (cur_ff.st == ST_STARTUP) || (cur_ff.st == ST_PRIMARY)
    || (cur_ff.st == ST_PWRUP);
  // rc kept alive for monitor, watchdog, or as the clock itself
  assign rc_osc_en_out = cur_ff.clock_monitor_enable_cfg | cur_ff.wdt_en
    | (cur_ff.cur_src == SRC_RC);
  assign wdt_timeout_out = cur_ff.wdt_to;
  assign cpu_resume_out = cur_ff.resume;
endmodule
`default_nettype wire

// ==== hdl/tsf_pkg.sv ====
// shared constants and types for the two-speed start-up and fail-safe clock block
`default_nettype none
package tsf_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_WDT = 8'h10;
  localparam logic [7:0] OFS_WDT_CNT = 8'h14;
  // ==========================================================
  // field positions
  localparam int OSC_RUN_BIT = 3;
  localparam int SCS_LSB = 0;
  localparam int FAIL_FLAG_BIT = 7;
  localparam int CFG_TWO_SPEED_BIT = 0;
  localparam int CFG_MON_BIT = 1;
  localparam int CFG_MODE_LSB = 2;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_FAIL_IE_BIT = 1;
  localparam int CTRL_CLRWDT_BIT = 2;
  localparam int WDT_EN_BIT = 0;
  localparam int WDT_PS_LSB = 4;
  // ==========================================================
  // values after reset and counts
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [3:0] WDT_PS_RST = 4'hF;
  localparam int SAMPLE_DIV = 64;
  localparam int OST_CYCLES_DEF = 1024;
  localparam int WDT_DIV_DEF = 64;
  // ==========================================================
  // clock sources, primary modes, sequencer states
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00, SRC_PRI = 2'b01, SRC_SEC = 2'b10, SRC_RC = 2'b11
  } tsf_src_t;
  typedef enum logic [1:0] {
    MODE_CRYSTAL_HIGH_SPEED = 2'b00, MODE_CRYSTAL_PLL = 2'b01,
    MODE_EXTERNAL_CLOCK = 2'b10, MODE_EXTERNAL_CLOCK_PLL = 2'b11
  } tsf_mode_t;
  typedef enum logic [2:0] {
    ST_PWRUP = 3'b000, ST_STARTUP = 3'b001, ST_PRIMARY = 3'b010,
    ST_FAILSAFE = 3'b011, ST_PM = 3'b100, ST_SLEEP = 3'b101
  } tsf_state_t;
endpackage
`default_nettype wire

// ==== hdl/tsf_mon_if.sv ====
// signals between the sequencer and the fail-safe clock monitor
`timescale 1ns/100ps
`default_nettype none
interface tsf_mon_if;
  logic enable;
  logic dev_clk;
  logic rc_clk;
  logic sample_clk;
  logic fail;
  modport seq (output enable, output dev_clk, output rc_clk, input sample_clk, input fail);
  modport mon (input enable, input dev_clk, input rc_clk, output sample_clk, output fail);
endinterface
`default_nettype wire

// ==== hdl/tsf_monitor.sv ====
// fail-safe monitor: sample clock divider, monitor latch and failure test
`timescale 1ns/100ps
`default_nettype none
module tsf_monitor
  import tsf_pkg::*;
#(
  parameter int DIV = SAMPLE_DIV
)
(
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  tsf_mon_if.mon mon // monitor side
);
  localparam int DW = $clog2(DIV);
  typedef struct packed {
    logic rc_prev;
    logic dev_prev;
    logic [DW-1:0] div;
    logic monitor_latch;
    logic fail;
  } tsf_mon_t;
  tsf_mon_t cur_ff;
  tsf_mon_t nxt_ff;
  logic rc_rise;
  logic smp_rise;
  logic smp_fall;
  logic dev_fall;
  // ==========================================================
  // edge detection and latch
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.rc_prev = mon.rc_clk;
    nxt_ff.dev_prev = mon.dev_clk;
    nxt_ff.fail = 1'b0;
    rc_rise = mon.rc_clk & ~cur_ff.rc_prev;
    dev_fall = cur_ff.dev_prev & ~mon.dev_clk;
    // divider always runs: the rc reference never stops while monitoring
    if (rc_rise)
      nxt_ff.div = cur_ff.div + 1'b1;
    smp_rise = rc_rise && (cur_ff.div == DW'(DIV / 2 - 1));
    smp_fall = rc_rise && (cur_ff.div == DW'(DIV - 1));
    if (!mon.enable)
      nxt_ff.monitor_latch = 1'b0;
    else
    begin
      if (dev_fall)
        nxt_ff.monitor_latch = 1'b1;
      if (smp_rise)
        nxt_ff.monitor_latch = 1'b0;
      // failure tested on sample falling edge only
      if (smp_fall && cur_ff.monitor_latch && !dev_fall)
        nxt_ff.fail = 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      cur_ff <= '0;
    else
      cur_ff <= nxt_ff;
  end
  assign mon.sample_clk = cur_ff.div[DW-1];
  assign mon.fail = cur_ff.fail;
endmodule
`default_nettype wire

// ==== tb/tsf_osc_model.sv ====
// behavioural model of the primary, secondary and internal rc oscillators
`timescale 1ns/100ps
`default_nettype none
module tsf_osc_model #(
  parameter int PRI_HALF = 5,
  parameter int SEC_HALF = 9,
  parameter int RC_HALF = 2
)
(
  input wire logic clk, // bench clock
  input wire logic pri_en, // primary enable from the block
  input wire logic dead, // primary crystal broken
  output logic pri_clk, // primary level
  output logic sec_clk, // secondary level
  output logic rc_clk, // internal rc level
  output logic pll_lock // pll locked
);
  int pc = 0;
  int sc = 0;
  int rc = 0;
  initial
  begin
    pri_clk = 1'b0;
    sec_clk = 1'b0;
    rc_clk = 1'b0;
    pll_lock = 1'b0;
  end
  // ==========================================================
  // primary stands low while disabled or broken, lock follows it
  always @(posedge clk)
  begin
    if (!pri_en || dead)
    begin
      pri_clk <= 1'b0;
      pc <= 0;
      pll_lock <= 1'b0;
    end
    else if (pc == PRI_HALF - 1)
    begin
      pri_clk <= !pri_clk;
      pc <= 0;
      pll_lock <= 1'b1;
    end
    else
      pc <= pc + 1;
  end
  // ==========================================================
  // secondary and rc run free, rc is never gated off
  always @(posedge clk)
  begin
    sc <= (sc == SEC_HALF - 1) ? 0 : sc + 1;
    rc <= (rc == RC_HALF - 1) ? 0 : rc + 1;
    if (sc == SEC_HALF - 1)
      sec_clk <= !sec_clk;
    if (rc == RC_HALF - 1)
      rc_clk <= !rc_clk;
  end
endmodule
`default_nettype wire

// ==== tb/tsf_top_sva.sv ====
// concurrent checks on the clock supervision top ports
`timescale 1ns/100ps
`default_nettype none
module tsf_top_sva
  import tsf_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // sync reset
  input wire logic idle_in, // core idle
  input wire logic irq_in, // interrupt pending
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic dev_clk_out, // device clock
  input wire tsf_pkg::tsf_src_t dev_src_out, // selected source
  input wire logic fail_safe_out, // fail-safe active
  input wire logic pri_osc_en_out, // primary enable
  input wire logic rc_osc_en_out, // rc enable
  input wire logic cpu_resume_out // resume pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // fail-safe entry, stay and exit
  property p_fail_src; $rose(fail_safe_out) |-> ##[0:40] dev_src_out == SRC_RC; endproperty
  a_fail_src: assert property (p_fail_src) else $error("no switch to rc after failure");
  property p_fail_from; $rose(fail_safe_out) |-> $past(dev_src_out) inside {SRC_PRI, SRC_SEC};
  endproperty
  a_fail_from: assert property (p_fail_from) else $error("failure on unsupervised source");
  // only a register write may end fail-safe, reset is the disable
  property p_fail_hold; fail_safe_out && !(psel && penable && pwrite) |=> fail_safe_out;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail-safe left on its own");
  property p_fail_rc; fail_safe_out && dev_src_out == SRC_RC |-> rc_osc_en_out; endproperty
  a_fail_rc: assert property (p_fail_rc) else $error("rc off while backing up");
  property p_no_return; fail_safe_out |-> !pri_osc_en_out; endproperty
  a_no_return: assert property (p_no_return) else $error("failed primary enabled again");
  // ==========================================================
  // clock switch and source relations
  property p_sw_low; $changed(dev_src_out) |-> !dev_clk_out; endproperty
  a_sw_low: assert property (p_sw_low) else $error("source switched with clock high");
  property p_none_low; dev_src_out == SRC_NONE |-> !dev_clk_out; endproperty
  a_none_low: assert property (p_none_low) else $error("clock with no source");
  property p_pri_en; dev_src_out == SRC_PRI && !fail_safe_out |-> pri_osc_en_out; endproperty
  a_pri_en: assert property (p_pri_en) else $error("primary clocks while disabled");
  property p_resume; !(idle_in && irq_in) |=> !cpu_resume_out; endproperty
  a_resume: assert property (p_resume) else $error("resume without idle interrupt");
  // ==========================================================
  // main scenarios seen
  c_fail: cover property ($rose(fail_safe_out));
  c_rc: cover property (dev_src_out == SRC_RC);
  c_resume: cover property (cpu_resume_out);
endmodule
bind tsf_top tsf_top_sva u_tsf_top_sva (
  .clk(clk), .reset(reset), .idle_in(idle_in), .irq_in(irq_in), .psel(psel),
  .penable(penable), .pwrite(pwrite), .dev_clk_out(dev_clk_out),
  .dev_src_out(dev_src_out), .fail_safe_out(fail_safe_out),
  .pri_osc_en_out(pri_osc_en_out), .rc_osc_en_out(rc_osc_en_out),
  .cpu_resume_out(cpu_resume_out)
);
`default_nettype wire

// ==== tb/two_speed_startup_fail_safe_clock_bench.sv ====
// self-checking bench for the clock supervision block
`timescale 1ns/100ps
`default_nettype none
module two_speed_startup_fail_safe_clock_bench;
  import tsf_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic por_in = 1'b1;
  logic pwrt_done_in = 1'b0;
  logic wake_in = 1'b0;
  logic idle_in = 1'b0;
  logic irq_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pri_dead = 1'b0;
  logic [31:0] prdata, rd, rnd;
  logic pready, pslverr, err, dev_clk_out, fail_safe_out, pri_osc_en_out, rc_osc_en_out;
  logic wdt_timeout_out, cpu_resume_out, pri_clk, sec_clk, rc_clk, pll_lock;
  tsf_src_t dev_src_out;
  int errors = 0;
  int n_tests = 0;
  tsf_top #(.OST_CYCLES(4), .WDT_DIV(4)) u_tsf_top (.clk(clk), .reset(reset),
    .por_in(por_in), .pwrt_done_in(pwrt_done_in), .pri_clk_in(pri_clk), .sec_clk_in(sec_clk),
    .rc_clk_in(rc_clk), .pll_lock_in(pll_lock), .wake_in(wake_in), .idle_in(idle_in),
    .irq_in(irq_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_clk_out(dev_clk_out), .dev_src_out(dev_src_out), .fail_safe_out(fail_safe_out),
    .pri_osc_en_out(pri_osc_en_out), .rc_osc_en_out(rc_osc_en_out),
    .wdt_timeout_out(wdt_timeout_out), .cpu_resume_out(cpu_resume_out));
  tsf_osc_model u_tsf_osc_model (.clk(clk), .pri_en(pri_osc_en_out), .dead(pri_dead),
    .pri_clk(pri_clk), .sec_clk(sec_clk), .rc_clk(rc_clk), .pll_lock(pll_lock));
  // ==========================================================
  // clock, random idle and interrupt traffic, watchdog
  initial
    forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    idle_in <= 1'($urandom_range(1, 0));
    irq_in <= 1'($urandom_range(1, 0));
  end
  initial
  begin
    #500us;
    errors++;
    report_and_stop();
  end
  // ==========================================================
  // helpers: expectation, compare, apb cycle, reset, source wait
  function automatic logic [31:0] exp_osc(input logic run, input logic [1:0] sel);
    return {28'h0, run, 1'b0, sel};
  endfunction
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, s);
    end
  endtask
  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    pwrt_done_in <= 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
  endtask
  task automatic wait_src();
    for (int i = 0; i < 500 && dev_src_out === SRC_NONE; i++) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial
  begin
    void'($urandom(3));
    do_reset();
    apb(1'b0, OFS_OSC_CTRL, 32'h0);
    chk("osc_ctrl_reset", exp_osc(1'b0, SCS_RST), rd);
    apb(1'b0, OFS_WDT, 32'h0);
    chk("wdt_reset", {24'h0, WDT_PS_RST, 4'h0}, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_data", 32'h0, rd);
    chk("unmapped_err", 32'h1, {31'h0, err});
    // two-speed on a crystal, reserved bits random
    rnd = $urandom();
    apb(1'b1, OFS_CFG, {rnd[27:0], 4'h1});
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg_reserved", 32'h1, rd);
    pwrt_done_in <= 1'b1;
    wait_src();
    chk("two_speed_src", 32'(SRC_RC), 32'(dev_src_out));
    apb(1'b0, OFS_OSC_CTRL, 32'h0);
    chk("run_bit_startup", exp_osc(1'b0, 2'h0), rd);
    for (int i = 0; i < 60 && rd[3] !== 1'b1; i++) apb(1'b0, OFS_OSC_CTRL, 32'h0);
    chk("run_bit_primary", exp_osc(1'b1, 2'h0), rd);
    repeat (20) @(posedge clk);
    chk("primary_src", 32'(SRC_PRI), 32'(dev_src_out));
    // monitor off: no failure however long
    repeat (700) @(posedge clk);
    chk("monitor_off", 32'h0, {31'h0, fail_safe_out});
    apb(1'b1, OFS_WDT, 32'hF1);
    apb(1'b1, OFS_CFG, 32'h2);
    for (int i = 0; i < 3000 && fail_safe_out !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    chk("fail_detect", 32'h1, {31'h0, fail_safe_out});
    // postscaler restarts from the clock change
    apb(1'b0, OFS_WDT_CNT, 32'h0);
    chk("wdt_cleared", 32'h0, rd);
    apb(1'b0, OFS_IRQ_FLAGS, 32'h0);
    chk("fail_flag", 32'h80, rd);
    apb(1'b0, OFS_OSC_CTRL, 32'h0);
    chk("ctrl_kept", exp_osc(1'b1, 2'h0), rd);
    chk("fail_src", 32'(SRC_RC), 32'(dev_src_out));
    apb(1'b1, OFS_IRQ_FLAGS, 32'h80);
    apb(1'b0, OFS_IRQ_FLAGS, 32'h0);
    chk("flag_clear", 32'h0, rd);
    apb(1'b1, OFS_OSC_CTRL, 32'h3);
    @(negedge clk);
    chk("fail_exit", 32'h0, {31'h0, fail_safe_out});
    // shortest postscale tap: a time-out pulse must come on the rc divider
    apb(1'b1, OFS_WDT, 32'h01);
    for (int i = 0; i < 100 && wdt_timeout_out !== 1'b1; i++) @(negedge clk);
    chk("wdt_timeout", 32'h1, {31'h0, wdt_timeout_out});
    // two-speed off: the first source is the primary
    do_reset();
    pwrt_done_in <= 1'b1;
    wait_src();
    chk("no_two_speed", 32'(SRC_PRI), 32'(dev_src_out));
    // broken crystal after reset: stay on rc, select still accepted
    do_reset();
    pri_dead <= 1'b1;
    apb(1'b1, OFS_CFG, 32'h3);
    pwrt_done_in <= 1'b1;
    wait_src();
    repeat (300) @(posedge clk);
    apb(1'b0, OFS_OSC_CTRL, 32'h0);
    chk("dead_ctrl", exp_osc(1'b0, SCS_RST), rd);
    chk("dead_src", 32'(SRC_RC), 32'(dev_src_out));
    chk("dead_no_fail", 32'h0, {31'h0, fail_safe_out});
    // sleep taken before the start-up timer expires, wake returns to rc
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    chk("sleep_in_startup", 32'(SRC_NONE), 32'(dev_src_out));
    wake_in <= 1'b1;
    @(posedge clk);
    wake_in <= 1'b0;
    repeat (6) @(posedge clk);
    chk("wake_rc", 32'(SRC_RC), 32'(dev_src_out));
    apb(1'b1, OFS_OSC_CTRL, 32'h3);
    apb(1'b0, OFS_OSC_CTRL, 32'h0);
    chk("select_in_startup", exp_osc(1'b0, 2'h3), rd);
    report_and_stop();
  end
endmodule
`default_nettype wire
